// file: include/subidle_defs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes a 40 MHz bus clock and a single AHB-Lite slave port
`ifndef SUBIDLE_DEFS_SVH
`define SUBIDLE_DEFS_SVH
// Byte offsets of the word registers
`define OFF_CAUSE        12'h000
`define OFF_PSC          12'h004
`define OFF_PROTECT      12'h008
`define OFF_CTRL         12'h00c
`define OFF_STATUS       12'h010
// Cause flag positions
`define BIT_WDT_CAUSE    0
`define BIT_CLM_CAUSE    1
`define BIT_UV_CAUSE     2
`define CAUSE_USED       8'h07
// Power-save control positions
`define BIT_WDT_NMI_MASK 0
`define BIT_PIN_NMI_MASK 1
`define BIT_MASKABLE_MASK 2
`define PSC_RESET        8'h00
// Control register positions
`define BIT_ENTER        0
`define BIT_LOW_VOLTAGE  1
`define BIT_PLL_ON       2
// Protected-write unlock key
`define PROTECT_KEY      8'ha5
// Release delay in subclock cycles
`define RELEASE_SUB_CYCLES 4'd12
// Stabilization window in bus cycles
`define STAB_CYCLES      8'd64
`define FETCH_ADDR       32'h0000_0000
`endif

// file: include/subidle_pkg.sv
// Types shared by the standby release and reset cause block
// Assumes the defs header supplies the numeric constants
package subidle_pkg;
	// Operating mode after release
	typedef enum logic [1:0] {MODE_MAIN, MODE_SUB, MODE_LV_SUB, MODE_EMERG} op_mode_e;
	// Standby sequencer states
	typedef enum logic [2:0] {ST_RUN, ST_IDLE, ST_WAIT, ST_RESET, ST_STAB} seq_e;
endpackage

// file: logic/subidle_ctrl.sv
// Standby release, reset source handling and reset-cause flag register
// Assumes an AHB-Lite master, synchronous inputs and a subclock tick strobe
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`include "subidle_defs.svh"
module subidle_ctrl (
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic                  hsel,
	input  wire logic [11:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic [31:0]                hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	input  wire logic                  sub_tick,
	input  wire logic                  reset_pin_n,
	input  wire logic                  watchdog_reset_request,
	input  wire logic                  undervoltage_reset,
	input  wire logic                  clock_monitor_reset,
	input  wire logic                  pin_nmi,
	input  wire logic                  watchdog_nonmaskable_irq,
	input  wire logic [7:0]            external_irq_pins,
	input  wire logic                  periph_irq,
	input  wire logic                  irq_globally_enabled,
	input  wire logic                  higher_prio_active,
	output logic                       system_reset_n,
	output logic                       detector_reset_n,
	output logic                       in_standby,
	output logic                       pll_run,
	output subidle_pkg::op_mode_e      op_mode,
	output logic                       nmi_ack,
	output logic                       maskable_ack,
	output logic                       maskable_pending,
	output logic [31:0]                fetch_addr
);
	import subidle_pkg::*;

	// Bus phase capture
	logic        wr_pend_r;
	logic        rd_pend_r;
	logic [11:0] addr_r;
	logic [3:0]  lane_r;
	// Software state
	logic [7:0]  cause_r;
	logic [7:0]  cause_nxt;
	logic [7:0]  psc_r;
	logic        unlock_r;
	logic        enter_r;
	logic        low_volt_r;
	logic        pll_cfg_r;
	// Sequencer
	seq_e        state_r;
	logic [3:0]  sub_cnt_r;
	logic [7:0]  stab_cnt_r;
	logic        woke_nmi_r;
	logic        woke_mask_r;
	logic        any_reset;
	logic        nmi_wake;
	logic        mask_wake;
	logic        int_reset;
	logic        wr_now;
	logic        release_now; // Twelfth tick seen while waiting to leave standby

	// Masked sources are dropped before they can wake the block
	assign nmi_wake  = (pin_nmi & ~psc_r[`BIT_PIN_NMI_MASK]) |
		(watchdog_nonmaskable_irq & ~psc_r[`BIT_WDT_NMI_MASK]);
	assign mask_wake = (|external_irq_pins | periph_irq) & ~psc_r[`BIT_MASKABLE_MASK];
	// Any of the four sources resets the system
	assign int_reset = watchdog_reset_request | undervoltage_reset | clock_monitor_reset;
	assign any_reset = ~reset_pin_n | int_reset;
	assign wr_now    = wr_pend_r;
	// Shared by the release outcome checks below
	assign release_now = (state_r == ST_WAIT) && sub_tick && (sub_cnt_r == `RELEASE_SUB_CYCLES - 4'd1);

	// Address phase capture; slave is always ready, response always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r    <= 12'h000;
			lane_r    <= 4'h0;
		end else begin
			wr_pend_r <= hsel & hready & htrans[1] & hwrite;
			rd_pend_r <= hsel & hready & htrans[1] & ~hwrite;
			if (hsel & hready & htrans[1]) begin
				addr_r <= haddr;
				// Byte lane for byte access, all lanes otherwise
				lane_r <= (hsize == 3'b000) ? (4'h1 << haddr[1:0]) : 4'hf;
			end
		end
	end

	// Read data: registered so every output comes from a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (hsel & hready & htrans[1] & ~hwrite) begin
				case (haddr)
					`OFF_CAUSE:   hrdata <= {24'h000000, cause_nxt & `CAUSE_USED};
					`OFF_PSC:     hrdata <= {24'h000000, psc_r};
					`OFF_PROTECT: hrdata <= {31'h0, unlock_r};
					`OFF_CTRL:    hrdata <= {29'h0, pll_cfg_r, low_volt_r, enter_r};
					`OFF_STATUS:  hrdata <= {27'h0, state_r, op_mode};
					default:      hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Protected sequence: key write arms only the next write, and only if that is a cause write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			unlock_r <= 1'b0;
		end else if (wr_now) begin
			unlock_r <= (addr_r == `OFF_PROTECT) && (hwdata[7:0] == `PROTECT_KEY);
		end
	end

	// Cause flags: software can only clear, and a new set wins
	always_comb begin
		cause_nxt = cause_r;
		if (wr_now && unlock_r && addr_r == `OFF_CAUSE && lane_r[0]) begin
			cause_nxt = cause_r & hwdata[7:0];
		end
		if (watchdog_reset_request) begin
			cause_nxt[`BIT_WDT_CAUSE] = 1'b1;
		end
		if (clock_monitor_reset) begin
			cause_nxt[`BIT_CLM_CAUSE] = 1'b1;
		end
		if (undervoltage_reset) begin
			cause_nxt[`BIT_UV_CAUSE] = 1'b1;
		end
		if (!reset_pin_n) begin
			cause_nxt = 8'h00;
		end
		cause_nxt = cause_nxt & `CAUSE_USED;
	end

	// Cause register survives internal resets; only hresetn, the pin and a protected write clear it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cause_r <= 8'h00;
		end else begin
			cause_r <= cause_nxt;
		end
	end

	// Power-save masks and standby controls; system resets reinit them
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			psc_r      <= `PSC_RESET;
			enter_r    <= 1'b0;
			low_volt_r <= 1'b0;
			pll_cfg_r  <= 1'b1;
		end else if (any_reset) begin
			psc_r      <= `PSC_RESET;
			enter_r    <= 1'b0;
			low_volt_r <= 1'b0;
			pll_cfg_r  <= 1'b1;
		end else if (wr_now && addr_r == `OFF_PSC && lane_r[0]) begin
			psc_r <= hwdata[7:0];
		end else if (wr_now && addr_r == `OFF_CTRL && lane_r[0]) begin
			enter_r    <= hwdata[`BIT_ENTER];
			low_volt_r <= hwdata[`BIT_LOW_VOLTAGE];
			pll_cfg_r  <= hwdata[`BIT_PLL_ON];
		end else if (state_r == ST_IDLE) begin
			enter_r <= 1'b0; // Standby request is consumed on entry
		end
	end

	// Standby and reset sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r     <= ST_STAB;
			sub_cnt_r   <= 4'd0;
			stab_cnt_r  <= 8'd0;
			woke_nmi_r  <= 1'b0;
			woke_mask_r <= 1'b0;
		end else if (any_reset) begin
			state_r    <= ST_RESET;
			sub_cnt_r  <= 4'd0;
			woke_nmi_r <= 1'b0;
			woke_mask_r <= 1'b0;
		end else begin
			case (state_r)
				ST_RUN: begin
					if (enter_r) begin
						state_r <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					// Priority plays no part in waking
					if (nmi_wake | mask_wake) begin
						state_r     <= ST_WAIT;
						sub_cnt_r   <= 4'd0;
						woke_nmi_r  <= nmi_wake;
						woke_mask_r <= mask_wake & ~nmi_wake;
					end
				end
				ST_WAIT: begin
					// Count subclock ticks before leaving standby
					if (sub_tick) begin
						if (sub_cnt_r == `RELEASE_SUB_CYCLES - 4'd1) begin
							state_r <= ST_RUN;
						end else begin
							sub_cnt_r <= sub_cnt_r + 4'd1;
						end
					end
				end
				ST_RESET: begin
					state_r    <= ST_STAB;
					stab_cnt_r <= 8'd0;
				end
				ST_STAB: begin
					// Wait for main oscillator to settle
					if (stab_cnt_r == `STAB_CYCLES - 8'd1) begin
						state_r <= ST_RUN;
					end else begin
						stab_cnt_r <= stab_cnt_r + 8'd1;
					end
				end
				default: state_r <= ST_RUN;
			endcase
		end
	end

	// Operating mode, PLL and acknowledge outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			op_mode          <= MODE_MAIN;
			pll_run          <= 1'b0;
			nmi_ack          <= 1'b0;
			maskable_ack     <= 1'b0;
			maskable_pending <= 1'b0;
			in_standby       <= 1'b0;
		end else begin
			nmi_ack      <= 1'b0;
			maskable_ack <= 1'b0;
			in_standby   <= (state_r == ST_IDLE) || (state_r == ST_WAIT);
			if (state_r == ST_RESET) begin
				op_mode          <= MODE_MAIN;
				pll_run          <= 1'b0;
				maskable_pending <= 1'b0;
			end else if (state_r == ST_STAB && watchdog_nonmaskable_irq) begin
				// Overflow while waiting on the oscillator: run on internal clock
				op_mode <= MODE_EMERG;
			end else if (state_r == ST_IDLE) begin
				pll_run <= 1'b0;
			end else if (state_r == ST_WAIT && sub_tick && sub_cnt_r == `RELEASE_SUB_CYCLES - 4'd1) begin
				op_mode <= low_volt_r ? MODE_LV_SUB : MODE_SUB;
				pll_run <= low_volt_r ? 1'b0 : pll_cfg_r;
				nmi_ack <= woke_nmi_r;
				// Acknowledge only if enabled and no higher handler running
				if (woke_mask_r) begin
					if (irq_globally_enabled && !higher_prio_active) begin
						maskable_ack <= 1'b1;
					end else begin
						maskable_pending <= 1'b1;
					end
				end
			end else if (state_r == ST_STAB && stab_cnt_r == `STAB_CYCLES - 8'd1) begin
				pll_run <= pll_cfg_r;
			end
		end
	end

	// Reset outputs; the detector is kept out of its own reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			system_reset_n   <= 1'b0;
			detector_reset_n <= 1'b0;
			fetch_addr       <= 32'h0000_0000;
		end else begin
			system_reset_n   <= ~any_reset && state_r != ST_RESET;
			detector_reset_n <= ~(~reset_pin_n | watchdog_reset_request | clock_monitor_reset);
			if (state_r == ST_RESET) begin
				fetch_addr <= `FETCH_ADDR;
			end
		end
	end

	// Standby is held until the twelfth tick after the wake request
	release_delay_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_r == ST_WAIT && sub_tick && sub_cnt_r != `RELEASE_SUB_CYCLES - 4'd1 && !any_reset)
		|=> state_r == ST_WAIT)
		else $error("standby left before twelve ticks");
	masked_nowake_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_r == ST_IDLE && !any_reset && psc_r == 8'h07) |=> state_r == ST_IDLE)
		else $error("masked source woke standby");
	reset_seq_a: assert property (@(posedge hclk) disable iff (!hresetn)
		any_reset |=> state_r == ST_RESET)
		else $error("reset did not start sequence");
	pin_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!reset_pin_n |=> cause_r == 8'h00)
		else $error("pin reset left cause flags");
	set_wins_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(watchdog_reset_request && reset_pin_n) |=> cause_r[`BIT_WDT_CAUSE])
		else $error("watchdog cause flag not set");
	cause_unused_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(cause_r & ~`CAUSE_USED) == 8'h00)
		else $error("unused cause bit set");
	ack_split_a: assert property (@(posedge hclk) disable iff (!hresetn)
		maskable_ack |-> $past(irq_globally_enabled) && !$past(higher_prio_active))
		else $error("maskable acked while blocked");
	lv_pll_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(op_mode == MODE_LV_SUB && $changed(op_mode)) |-> !pll_run)
		else $error("pll running after low voltage release");
	lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_now && !unlock_r && addr_r == `OFF_CAUSE && reset_pin_n && !int_reset) |=> $stable(cause_r))
		else $error("unprotected write changed cause");
	// Release outcomes, seen on the edge after the twelfth tick
	sub_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(release_now && !low_volt_r && !any_reset) |=> op_mode == MODE_SUB)
		else $error("ordinary release not in subclock mode");
	lv_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(release_now && low_volt_r && !any_reset) |=> op_mode == MODE_LV_SUB)
		else $error("low voltage release in wrong mode");
	nmi_ack_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(release_now && woke_nmi_r && !any_reset) |=> nmi_ack)
		else $error("waking nmi not acknowledged");
	pend_held_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(release_now && woke_mask_r && !irq_globally_enabled && !any_reset)
		|=> maskable_pending && !maskable_ack)
		else $error("disabled wake request not left pending");
	ack_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(release_now && woke_mask_r && irq_globally_enabled && !higher_prio_active && !any_reset)
		|=> maskable_ack)
		else $error("enabled wake request not acknowledged");
	// Reset side: sources, restart address, emergency and flag keeping
	sys_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
		any_reset |=> !system_reset_n)
		else $error("reset source did not reset system");
	fetch_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_r == ST_RESET) |=> fetch_addr == `FETCH_ADDR)
		else $error("restart address not zero");
	emerg_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_r == ST_STAB && watchdog_nonmaskable_irq && !any_reset) |=> op_mode == MODE_EMERG)
		else $error("overflow in wait gave no emergency mode");
	flags_kept_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(reset_pin_n && !wr_now) |=> (cause_r & $past(cause_r)) == $past(cause_r))
		else $error("cause flag lost without pin reset");
	uv_spare_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(undervoltage_reset && reset_pin_n && !watchdog_reset_request && !clock_monitor_reset)
		|=> detector_reset_n)
		else $error("undervoltage reset hit detector");
endmodule

// file: verif/far_side.sv
// Far-side model: subclock tick source and the four reset-source monitors
// Assumes the bench pulses one fire bit for a single hclk cycle per event
module far_side (
	input  wire logic       hclk,
	input  wire logic [3:0] fire,
	output logic            sub_tick,
	output logic            reset_pin_n,
	output logic            watchdog_reset_request,
	output logic            undervoltage_reset,
	output logic            clock_monitor_reset
);
	timeunit 1ns;
	timeprecision 1ps;
	int div     = 0;             // Subclock divider, free running like a crystal
	int hold[4] = '{0, 0, 0, 0}; // Cycles left on each reset source
	// One tick every fourth bus cycle, far quicker than a real subclock
	always @(posedge hclk) begin
		div <= (div + 1) % 4;
		sub_tick <= (div == 3);
	end
	// Fired source stays asserted four cycles, then the monitor lets go
	always @(posedge hclk) begin
		for (int i = 0; i < 4; i++) begin
			hold[i] <= fire[i] ? 4 : (hold[i] > 0 ? hold[i] - 1 : 0);
		end
	end
	assign reset_pin_n            = !(hold[0] > 0); // Pin is active low
	assign watchdog_reset_request = hold[1] > 0;
	assign undervoltage_reset     = hold[2] > 0;
	assign clock_monitor_reset    = hold[3] > 0;
endmodule

// file: verif/subidle_release_and_reset_cause_tb.sv
// Bench for standby release and reset-cause handling
// Assumes far_side supplies subclock ticks and reset sources
`include "subidle_defs.svh"
module subidle_release_and_reset_cause_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import subidle_pkg::*;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [11:0] haddr = '0;
	logic [1:0]  htrans = '0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = '0, hrdata, fetch_addr, rd;
	logic [7:0]  external_irq_pins = '0;
	logic        periph_irq = 0, pin_nmi = 0, watchdog_nonmaskable_irq = 0;
	logic        irq_globally_enabled = 0, higher_prio_active = 0;
	logic [3:0]  fire = '0;
	logic        hreadyout, hresp, sub_tick, reset_pin_n, watchdog_reset_request, undervoltage_reset;
	logic        clock_monitor_reset, system_reset_n, detector_reset_n, in_standby, pll_run;
	logic        nmi_ack, maskable_ack, maskable_pending;
	op_mode_e    op_mode;
	logic [31:0] seed = 32'h37;             // Xorshift state
	int          failures = 0, n_tests = 0; // Verdict counters
	int          ticks, acks, exp_cause = 0; // Model state
	int          bitv[4] = '{0, 1, 4, 2};    // Flag each source sets
	subidle_ctrl u_subidle_ctrl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .sub_tick, .reset_pin_n, .watchdog_reset_request,
		.undervoltage_reset, .clock_monitor_reset, .pin_nmi, .watchdog_nonmaskable_irq, .external_irq_pins,
		.periph_irq, .irq_globally_enabled, .higher_prio_active, .system_reset_n, .detector_reset_n,
		.in_standby, .pll_run, .op_mode, .nmi_ack, .maskable_ack, .maskable_pending, .fetch_addr);
	far_side u_far_side (.hclk, .fire, .sub_tick, .reset_pin_n, .watchdog_reset_request,
		.undervoltage_reset, .clock_monitor_reset);
	initial forever #12.5 hclk = ~hclk;
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task test_done();
		$display("Checks %0d, failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// One single word transfer; read data taken at the closing edge
	task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// Drive one wake source; pin choice is random
	task src(input int s, input logic v);
		case (s)
			0: external_irq_pins <= v ? 8'h1 << (xs() % 32'h8) : 8'h0;
			1: periph_irq <= v;
			2: pin_nmi <= v;
			default: watchdog_nonmaskable_irq <= v;
		endcase
	endtask
	// Enter standby, wake just after a tick, count ticks and acks
	task stby(input logic [31:0] ctl, input int s);
		bus(1'b1, `OFF_CTRL, ctl);
		repeat (3) @(posedge hclk);
		do @(posedge hclk); while (sub_tick !== 1'b1);
		src(s, 1'b1);
		ticks = 0;
		acks = 0;
		repeat (60) begin
			@(posedge hclk);
			if (sub_tick === 1'b1 && in_standby === 1'b1) ticks++;
			if ((s < 2 ? maskable_ack : nmi_ack) === 1'b1) acks++;
		end
		src(s, 1'b0);
	endtask
	// Fire a reset source, wait out reset and stabilization, read flags
	task rst(input int s);
		@(posedge hclk) fire[s] <= 1'b1;
		@(posedge hclk) fire <= '0;
		ticks = 0;
		while (system_reset_n !== 1'b0 && ticks < 10) begin
			@(posedge hclk);
			ticks++;
		end
		chk("sys_rst", system_reset_n, 0);
		chk("det_rst", detector_reset_n, s == 2);
		while (system_reset_n !== 1'b1) @(posedge hclk);
		repeat (70) @(posedge hclk);
		exp_cause = s == 0 ? 0 : exp_cause | bitv[s];
		bus(1'b0, `OFF_CAUSE, 0);
		chk("cause", rd, exp_cause);
	endtask
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		chk("fetch", fetch_addr, 0);
		bus(1'b0, 12'h100, 0);
		chk("unmapped", rd, 0);
		// Standby entry is only honoured once the oscillator wait is over
		repeat (70) @(posedge hclk);
		chk("boot_mode", op_mode, MODE_MAIN);
		irq_globally_enabled <= 1'b1;
		// Every wake kind, interrupts enabled; odd kinds enter with the PLL off
		for (int s = 0; s < 4; s++) begin
			stby(s[0] ? 32'h1 : 32'h5, s);
			chk("ticks", ticks, 12);
			chk("mode", op_mode, MODE_SUB);
			chk("pll", pll_run, !s[0]);
			chk("ack", acks, 1);
		end
		higher_prio_active <= 1'b1;
		stby(32'h5, 1);
		chk("ack_hp", acks, 0);
		chk("pend_hp", maskable_pending, 1);
		chk("ticks_hp", ticks, 12);
		// Pin reset drops the pending request so the next case starts clean
		rst(0);
		chk("pend_clr", maskable_pending, 0);
		higher_prio_active <= 1'b0;
		irq_globally_enabled <= 1'b0;
		stby(32'h7, 0);
		chk("mode_lv", op_mode, MODE_LV_SUB);
		chk("pll_lv", pll_run, 0);
		chk("ack_di", acks, 0);
		chk("pend_di", maskable_pending, 1);
		stby(32'h5, 2);
		chk("ack_nmi_di", acks, 1);
		// All sources masked, then a watchdog reset ends standby
		bus(1'b1, `OFF_PSC, (xs() << 8) | 32'h7);
		stby(32'h5, 3);
		chk("masked", in_standby, 1);
		rst(1);
		chk("pend_rst", maskable_pending, 0);
		bus(1'b1, `OFF_CAUSE, 0);
		bus(1'b0, `OFF_CAUSE, 0);
		chk("unprot", rd, exp_cause);
		rst(2);
		rst(3);
		bus(1'b1, `OFF_PROTECT, `PROTECT_KEY);
		bus(1'b1, `OFF_CAUSE, 32'hfa);
		exp_cause &= 32'hfa;
		bus(1'b0, `OFF_CAUSE, 0);
		chk("clr", rd, exp_cause);
		rst(0);
		// Second bus reset; watchdog overflow in the stabilization wait
		@(posedge hclk) hresetn <= 1'b0;
		@(posedge hclk) hresetn <= 1'b1;
		repeat (10) @(posedge hclk);
		watchdog_nonmaskable_irq <= 1'b1;
		repeat (4) @(posedge hclk);
		watchdog_nonmaskable_irq <= 1'b0;
		repeat (70) @(posedge hclk);
		chk("emerg", op_mode, MODE_EMERG);
		// No peripheral access in emergency mode
		test_done();
	end
	// Hang guard, far beyond the expected twelve hundred or so cycles
	initial begin
		repeat (20000) @(posedge hclk);
		failures++;
		test_done();
	end
endmodule
